// *** fcp_pkg.sv ***
// Constants, types and helpers shared by the flash code protection block
package fcp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] SFR_FLASH_CTRL    = 16'h00b2;
	localparam logic [15:0] SFR_PAGE_SELECT   = 16'h00b7;
	localparam logic [15:0] SFR_ERASE_CMD     = 16'h0094;
	localparam logic [15:0] IORAM_MODIFY_KEY  = 16'h2702;
	localparam logic [15:0] IORAM_ENGINE_PAGE = 16'h2109;

	localparam int unsigned CTRL_BOOT_WINDOW_BIT = 7;
	localparam int unsigned CTRL_PROTECT_BIT     = 6;
	localparam int unsigned CTRL_MASS_ARM_BIT    = 1;
	localparam int unsigned PAGE_SELECT_LSB      = 1;
	localparam int unsigned MODIFY_KEY_LSB       = 4;

	localparam logic [3:0] MODIFY_KEY_VALUE   = 4'h2;
	localparam logic [7:0] ERASE_PAGE_PATTERN = 8'h55;
	localparam logic [7:0] ERASE_MASS_PATTERN = 8'haa;

	localparam logic [3:0] MODIFY_KEY_RESET  = 4'h0;
	localparam logic [6:0] PAGE_SELECT_RESET = 7'h00;
	localparam logic [5:0] ENGINE_PAGE_RESET = 6'h00;

	// ----------------------------------------------------------------
	// Flash geometry and boot timing
	// ----------------------------------------------------------------
	localparam int unsigned FLASH_ADDR_W      = 16;
	localparam int unsigned PAGE_ADDR_LSB     = 9;
	localparam int unsigned ENGINE_ADDR_LSB   = 10;
	localparam int unsigned BOOT_WINDOW_FLAG_CYCLES    = 64;
	localparam int unsigned EMU_INHIBIT_CYCLES = 60;
	localparam int unsigned BOOT_CNT_W        = 7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FCP_OP_READ,
		FCP_OP_WRITE,
		FCP_OP_PAGE_ERASE,
		FCP_OP_MASS_ERASE
	} fcp_op_e;

	typedef enum logic [1:0] {
		FCP_SRC_CPU,
		FCP_SRC_EMU,
		FCP_SRC_SPI
	} fcp_src_e;

	typedef struct packed {
		logic                    valid;
		fcp_op_e                 op;
		logic [FLASH_ADDR_W-1:0] addr;
		logic [7:0]              wdata;
	} fcp_req_s;

	typedef struct packed {
		logic                    valid;
		fcp_src_e                src;
		fcp_op_e                 op;
		logic [FLASH_ADDR_W-1:0] addr;
		logic [7:0]              wdata;
	} fcp_flash_cmd_s;

	typedef struct packed {
		logic done;
		logic denied;
	} fcp_resp_s;

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] fcp_page_of(input logic [FLASH_ADDR_W-1:0] addr);
		fcp_page_of = addr[FLASH_ADDR_W-1:PAGE_ADDR_LSB];
	endfunction

	function automatic logic [FLASH_ADDR_W-1:0] fcp_engine_base(input logic [5:0] page);
		fcp_engine_base = {page, 10'h000};
	endfunction

endpackage

// *** fcp_boot_seq.sv ***
// Boot cycle counter giving the pre-boot window and emulator inhibit
`timescale 1ns/100ps
module fcp_boot_seq #(
	parameter int unsigned BOOT_WINDOW_FLAG_CYCLES = fcp_pkg::BOOT_WINDOW_FLAG_CYCLES,
	parameter int unsigned INHIBIT_CYCLES = fcp_pkg::EMU_INHIBIT_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      boot_window,
	output logic      emu_inhibit
);

	typedef struct packed {
		logic [fcp_pkg::BOOT_CNT_W-1:0] cnt;
		logic                           window;
		logic                           inhibit;
	} fcp_boot_st_s;

	fcp_boot_st_s st_r;
	fcp_boot_st_s st_nxt;

	localparam logic [fcp_pkg::BOOT_CNT_W-1:0] PRE_END = fcp_pkg::BOOT_CNT_W'(BOOT_WINDOW_FLAG_CYCLES);
	localparam logic [fcp_pkg::BOOT_CNT_W-1:0] INH_END = fcp_pkg::BOOT_CNT_W'(INHIBIT_CYCLES);

	always_comb begin
		st_nxt = st_r;
		// Saturate so the window never reopens without a reset
		if (st_r.cnt != PRE_END) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
		st_nxt.window  = (st_nxt.cnt < PRE_END);
		st_nxt.inhibit = (st_nxt.cnt < INH_END);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '{cnt: '0, window: 1'b1, inhibit: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign boot_window = st_r.window;
	assign emu_inhibit = st_r.inhibit;

endmodule

// *** fcp_perm_check.sv ***
// Combinational permission check for one flash request
`timescale 1ns/100ps
module fcp_perm_check (
	input  wire fcp_pkg::fcp_src_e          src,
	input  wire fcp_pkg::fcp_op_e           op,
	input  wire logic [fcp_pkg::FLASH_ADDR_W-1:0] addr,
	input  wire logic                       protect,
	input  wire logic                       key_ok,
	input  wire logic                       emu_enabled,
	input  wire logic                       spi_flash_ok,
	input  wire logic [5:0]                 engine_page,
	output logic                            allow
);

	logic modify;
	logic page_zero;
	logic in_engine;

	always_comb begin
		modify    = (op != fcp_pkg::FCP_OP_READ);
		page_zero = (fcp_pkg::fcp_page_of(addr) == 7'h00);
		in_engine = (addr >= fcp_pkg::fcp_engine_base(engine_page));
		allow     = 1'b1;
		case (src)
			fcp_pkg::FCP_SRC_EMU: begin
				if (!emu_enabled) begin
					allow = 1'b0;
				end
				if (protect && op != fcp_pkg::FCP_OP_MASS_ERASE) begin
					allow = 1'b0;
				end
			end
			fcp_pkg::FCP_SRC_SPI: begin
				if (!spi_flash_ok) begin
					allow = 1'b0;
				end
				if (protect && op == fcp_pkg::FCP_OP_READ) begin
					allow = 1'b0;
				end
			end
			fcp_pkg::FCP_SRC_CPU: begin
				if (op == fcp_pkg::FCP_OP_MASS_ERASE && !emu_enabled) begin
					allow = 1'b0;
				end
			end
			default: allow = 1'b0;
		endcase
		if (modify && !key_ok) begin
			allow = 1'b0;
		end
		if (protect && op == fcp_pkg::FCP_OP_WRITE && page_zero) begin
			allow = 1'b0;
		end
		if (protect && op == fcp_pkg::FCP_OP_PAGE_ERASE && page_zero) begin
			allow = 1'b0;
		end
		if (protect && op == fcp_pkg::FCP_OP_PAGE_ERASE && in_engine) begin
			allow = 1'b0;
		end
	end

endmodule

// *** fcp_top.sv ***
// Flash code protection: registers, boot window, access gating and arbitration
`timescale 1ns/100ps
module fcp_top (
	input  wire logic                   CLK_SYS,
	input  wire logic                   SYS_RST,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	input  wire logic                   REG_IORAM,
	input  wire logic [15:0]            REG_ADDR,
	input  wire logic [7:0]             REG_WDATA,
	output logic      [7:0]             REG_RDATA,
	input  wire fcp_pkg::fcp_req_s      CPU_REQ,
	input  wire fcp_pkg::fcp_req_s      EMU_REQ,
	input  wire fcp_pkg::fcp_req_s      SPI_REQ,
	input  wire logic                   EMU_PORT_EN,
	input  wire logic                   SPM_ACTIVE,
	input  wire logic                   CPU_HALTED,
	input  wire logic                   SPI_RAM_REQ,
	output logic                        SPI_RAM_GRANT,
	output fcp_pkg::fcp_flash_cmd_s     FLASH_CMD,
	output fcp_pkg::fcp_resp_s          CPU_RESP,
	output fcp_pkg::fcp_resp_s          EMU_RESP,
	output fcp_pkg::fcp_resp_s          SPI_RESP,
	output logic                        BOOT_WINDOW,
	output logic                        EMU_ENABLED,
	output logic                        PROTECTED
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    protect;
		logic                    mass_arm;
		logic [6:0]              page_sel;
		logic [3:0]              modify_key;
		logic [5:0]              engine_page;
		fcp_pkg::fcp_req_s       erase_pend;
		logic [7:0]              rdata;
		fcp_pkg::fcp_flash_cmd_s cmd;
		fcp_pkg::fcp_resp_s      cpu_resp;
		fcp_pkg::fcp_resp_s      emu_resp;
		fcp_pkg::fcp_resp_s      spi_resp;
		logic                    ram_grant;
		logic                    boot_window;
		logic                    emu_enabled;
	} fcp_top_st_s;

	fcp_top_st_s st_r;
	fcp_top_st_s st_nxt;

	logic boot_window;
	logic emu_inhibit;
	logic emu_en_now;
	logic spi_flash_ok;
	logic key_ok;
	logic cpu_allow;
	logic emu_allow;
	logic spi_allow;
	fcp_pkg::fcp_req_s cpu_sel;

	// ----------------------------------------------------------------
	// Boot sequencing
	// ----------------------------------------------------------------
	fcp_boot_seq u_boot (
		.clk         (CLK_SYS),
		.rst         (SYS_RST),
		.boot_window (boot_window),
		.emu_inhibit (emu_inhibit)
	);

	assign emu_en_now   = EMU_PORT_EN & ~emu_inhibit;
	assign spi_flash_ok = SPM_ACTIVE & CPU_HALTED;
	assign key_ok       = (st_r.modify_key == fcp_pkg::MODIFY_KEY_VALUE);
	// Register-made erase takes the processor slot ahead of direct requests
	assign cpu_sel      = st_r.erase_pend.valid ? st_r.erase_pend : CPU_REQ;

	// ----------------------------------------------------------------
	// Permission checks, one per source
	// ----------------------------------------------------------------
	fcp_perm_check u_perm_cpu (
		.src          (fcp_pkg::FCP_SRC_CPU),
		.op           (cpu_sel.op),
		.addr         (cpu_sel.addr),
		.protect      (st_r.protect),
		.key_ok       (key_ok),
		.emu_enabled  (emu_en_now),
		.spi_flash_ok (spi_flash_ok),
		.engine_page  (st_r.engine_page),
		.allow        (cpu_allow)
	);

	fcp_perm_check u_perm_emu (
		.src          (fcp_pkg::FCP_SRC_EMU),
		.op           (EMU_REQ.op),
		.addr         (EMU_REQ.addr),
		.protect      (st_r.protect),
		.key_ok       (key_ok),
		.emu_enabled  (emu_en_now),
		.spi_flash_ok (spi_flash_ok),
		.engine_page  (st_r.engine_page),
		.allow        (emu_allow)
	);

	fcp_perm_check u_perm_spi (
		.src          (fcp_pkg::FCP_SRC_SPI),
		.op           (SPI_REQ.op),
		.addr         (SPI_REQ.addr),
		.protect      (st_r.protect),
		.key_ok       (key_ok),
		.emu_enabled  (emu_en_now),
		.spi_flash_ok (spi_flash_ok),
		.engine_page  (st_r.engine_page),
		.allow        (spi_allow)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic granted;
		granted = 1'b0;
		st_nxt  = st_r;

		st_nxt.cmd.valid   = 1'b0;
		st_nxt.cpu_resp    = '0;
		st_nxt.emu_resp    = '0;
		st_nxt.spi_resp    = '0;
		st_nxt.boot_window = boot_window;
		st_nxt.emu_enabled = emu_en_now;
		// RAM never opens to SPI in programming mode
		st_nxt.ram_grant   = SPI_RAM_REQ & ~SPM_ACTIVE;

		// Register reads, answered one cycle later
		if (REG_RD) begin
			st_nxt.rdata = 8'h00;
			if (!REG_IORAM) begin
				case (REG_ADDR)
					fcp_pkg::SFR_FLASH_CTRL: begin
						st_nxt.rdata[fcp_pkg::CTRL_BOOT_WINDOW_BIT] = boot_window;
						st_nxt.rdata[fcp_pkg::CTRL_PROTECT_BIT]     = st_r.protect;
						st_nxt.rdata[fcp_pkg::CTRL_MASS_ARM_BIT]    = st_r.mass_arm;
					end
					fcp_pkg::SFR_PAGE_SELECT: begin
						st_nxt.rdata = {st_r.page_sel, 1'b0};
					end
					default: st_nxt.rdata = 8'h00;
				endcase
			end else begin
				case (REG_ADDR)
					fcp_pkg::IORAM_MODIFY_KEY:  st_nxt.rdata = {st_r.modify_key, 4'h0};
					fcp_pkg::IORAM_ENGINE_PAGE: st_nxt.rdata = {2'b00, st_r.engine_page};
					default:                    st_nxt.rdata = 8'h00;
				endcase
			end
		end

		// Flash arbitration: SPI, then emulator, then processor
		if (SPI_REQ.valid) begin
			if (spi_allow) begin
				granted          = 1'b1;
				st_nxt.cmd       = '{valid: 1'b1, src: fcp_pkg::FCP_SRC_SPI, op: SPI_REQ.op,
					addr: SPI_REQ.addr, wdata: SPI_REQ.wdata};
				st_nxt.spi_resp.done = 1'b1;
			end else begin
				st_nxt.spi_resp.denied = 1'b1;
			end
		end
		if (EMU_REQ.valid) begin
			if (emu_allow && !granted) begin
				granted          = 1'b1;
				st_nxt.cmd       = '{valid: 1'b1, src: fcp_pkg::FCP_SRC_EMU, op: EMU_REQ.op,
					addr: EMU_REQ.addr, wdata: EMU_REQ.wdata};
				st_nxt.emu_resp.done = 1'b1;
			end else begin
				st_nxt.emu_resp.denied = 1'b1;
			end
		end
		if (cpu_sel.valid) begin
			if (cpu_allow && !granted) begin
				st_nxt.cmd       = '{valid: 1'b1, src: fcp_pkg::FCP_SRC_CPU, op: cpu_sel.op,
					addr: cpu_sel.addr, wdata: cpu_sel.wdata};
				st_nxt.cpu_resp.done = 1'b1;
			end else begin
				st_nxt.cpu_resp.denied = 1'b1;
			end
		end
		// A direct request that lost the slot to a pending erase is refused
		if (st_r.erase_pend.valid && CPU_REQ.valid) begin
			st_nxt.cpu_resp.denied = 1'b1;
		end
		// Pending erase lives exactly one cycle, granted or not
		st_nxt.erase_pend.valid = 1'b0;

		// Register writes
		if (REG_WR) begin
			if (!REG_IORAM) begin
				case (REG_ADDR)
					fcp_pkg::SFR_FLASH_CTRL: begin
						// Only a one in the window arms; nothing here can disarm
						// Live window: the registered copy would admit a 65th cycle
						if (REG_WDATA[fcp_pkg::CTRL_PROTECT_BIT] && boot_window) begin
							st_nxt.protect = 1'b1;
						end
						st_nxt.mass_arm = REG_WDATA[fcp_pkg::CTRL_MASS_ARM_BIT];
					end
					fcp_pkg::SFR_PAGE_SELECT: begin
						st_nxt.page_sel = REG_WDATA[7:fcp_pkg::PAGE_SELECT_LSB];
					end
					fcp_pkg::SFR_ERASE_CMD: begin
						if (REG_WDATA == fcp_pkg::ERASE_PAGE_PATTERN) begin
							st_nxt.erase_pend = '{valid: 1'b1, op: fcp_pkg::FCP_OP_PAGE_ERASE,
								addr: {st_r.page_sel, 9'h000}, wdata: 8'h00};
						end else if (REG_WDATA == fcp_pkg::ERASE_MASS_PATTERN &&
							st_r.mass_arm) begin
							st_nxt.erase_pend = '{valid: 1'b1, op: fcp_pkg::FCP_OP_MASS_ERASE,
								addr: '0, wdata: 8'h00};
						end
						// Arm is single use, so a stray pattern later cannot mass erase
						st_nxt.mass_arm = 1'b0;
					end
					default: ;
				endcase
			end else begin
				case (REG_ADDR)
					fcp_pkg::IORAM_MODIFY_KEY: begin
						// Held until software rewrites it; no auto clear
						st_nxt.modify_key = REG_WDATA[7:fcp_pkg::MODIFY_KEY_LSB];
					end
					fcp_pkg::IORAM_ENGINE_PAGE: begin
						st_nxt.engine_page = REG_WDATA[5:0];
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			st_r             <= '0;
			st_r.protect     <= 1'b0;
			st_r.modify_key  <= fcp_pkg::MODIFY_KEY_RESET;
			st_r.page_sel    <= fcp_pkg::PAGE_SELECT_RESET;
			st_r.engine_page <= fcp_pkg::ENGINE_PAGE_RESET;
			st_r.boot_window <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA     = st_r.rdata;
	assign FLASH_CMD     = st_r.cmd;
	assign CPU_RESP      = st_r.cpu_resp;
	assign EMU_RESP      = st_r.emu_resp;
	assign SPI_RESP      = st_r.spi_resp;
	assign SPI_RAM_GRANT = st_r.ram_grant;
	assign BOOT_WINDOW   = st_r.boot_window;
	assign EMU_ENABLED   = st_r.emu_enabled;
	assign PROTECTED     = st_r.protect;

endmodule

// *** fcp_top_sva.sv ***
// Port-level checker for the flash code protection block
`timescale 1ns/100ps
module fcp_top_sva (
	input wire logic                    CLK_SYS,
	input wire logic                    SYS_RST,
	input wire fcp_pkg::fcp_req_s       EMU_REQ,
	input wire fcp_pkg::fcp_req_s       SPI_REQ,
	input wire logic                    SPM_ACTIVE,
	input wire logic                    CPU_HALTED,
	input wire logic                    SPI_RAM_REQ,
	input wire logic                    SPI_RAM_GRANT,
	input wire fcp_pkg::fcp_flash_cmd_s FLASH_CMD,
	input wire fcp_pkg::fcp_resp_s      EMU_RESP,
	input wire fcp_pkg::fcp_resp_s      SPI_RESP,
	input wire logic                    BOOT_WINDOW,
	input wire logic                    EMU_ENABLED,
	input wire logic                    PROTECTED
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// ----------------------------------------------------------------
	// Cycles since reset release, saturating
	// ----------------------------------------------------------------
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	assign cnt_nxt = cnt_r + {7'h00, cnt_r != 8'hff};
	always_ff @(posedge CLK_SYS) begin
		cnt_r <= SYS_RST ? 8'h00 : cnt_nxt;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	window_early_a: assert property (cnt_r < 8'd65 |-> BOOT_WINDOW)
		else $error("boot window low too early");
	window_late_a: assert property (cnt_r > 8'd64 |-> !BOOT_WINDOW)
		else $error("boot window still high");
	emu_inhibit_a: assert property (cnt_r < 8'd61 |-> !EMU_ENABLED)
		else $error("emulator enabled during inhibit");
	arm_window_a: assert property ($rose(PROTECTED) |-> cnt_r <= 8'd64)
		else $error("protection armed outside window");
	protect_sticky_a: assert property (PROTECTED |=> PROTECTED)
		else $error("protection cleared without reset");
	emu_limit_a: assert property (EMU_REQ.valid && PROTECTED &&
		EMU_REQ.op != fcp_pkg::FCP_OP_MASS_ERASE |=> EMU_RESP.denied && !EMU_RESP.done)
		else $error("emulator request passed while protected");
	spi_gate_a: assert property (SPI_REQ.valid && !(SPM_ACTIVE && CPU_HALTED)
		|=> SPI_RESP.denied && !SPI_RESP.done)
		else $error("spi reached flash outside programming mode");
	spi_answer_a: assert property (SPI_REQ.valid |=> SPI_RESP.done ^ SPI_RESP.denied)
		else $error("spi request without single answer");
	page0_write_a: assert property (FLASH_CMD.valid && $past(PROTECTED) &&
		FLASH_CMD.op == fcp_pkg::FCP_OP_WRITE |-> FLASH_CMD.addr[15:9] != 7'h00)
		else $error("page zero written while protected");
	page0_erase_a: assert property (FLASH_CMD.valid && $past(PROTECTED) &&
		FLASH_CMD.op == fcp_pkg::FCP_OP_PAGE_ERASE |-> FLASH_CMD.addr[15:9] != 7'h00)
		else $error("page zero erased while protected");
	ram_closed_a: assert property (SPI_RAM_REQ && SPM_ACTIVE |=> !SPI_RAM_GRANT)
		else $error("ram granted in programming mode");
	arm_c: cover property ($rose(PROTECTED));
	spi_c: cover property (FLASH_CMD.valid && FLASH_CMD.src == fcp_pkg::FCP_SRC_SPI);
	mass_c: cover property (FLASH_CMD.valid && FLASH_CMD.op == fcp_pkg::FCP_OP_MASS_ERASE);
endmodule

bind fcp_top fcp_top_sva chk_i (.CLK_SYS, .SYS_RST, .EMU_REQ, .SPI_REQ, .SPM_ACTIVE,
	.CPU_HALTED, .SPI_RAM_REQ, .SPI_RAM_GRANT, .FLASH_CMD, .EMU_RESP, .SPI_RESP,
	.BOOT_WINDOW, .EMU_ENABLED, .PROTECTED);

// *** fcp_spi_host.sv ***
// Behavioural external SPI master issuing flash requests
`timescale 1ns/100ps
module fcp_spi_host (
	input  wire logic             clk,
	input  wire logic             start,
	input  wire fcp_pkg::fcp_op_e op,
	input  wire logic [15:0]      addr,
	input  wire logic             spm_want,
	input  wire logic             ram_want,
	output fcp_pkg::fcp_req_s     req,
	output logic                  spm,
	output logic                  ram_req
);
	initial begin
		req = '0;
		spm = 1'b0;
		ram_req = 1'b0;
	end
	// Idle address and data carry inverted values so stale data is never mistaken
	always @(posedge clk) begin
		spm <= spm_want;
		ram_req <= ram_want;
		if (start) begin
			req <= fcp_pkg::fcp_req_s'{1'b1, op, addr, addr[7:0]};
		end else begin
			req <= fcp_pkg::fcp_req_s'{1'b0, op, ~addr, ~addr[7:0]};
		end
	end
endmodule

// *** flash_code_protection_tb_top.sv ***
// Self-checking bench for the flash code protection block
`timescale 1ns/100ps
module flash_code_protection_tb_top;
	logic CLK_SYS, SYS_RST, REG_WR, REG_RD, REG_IORAM, EMU_PORT_EN, CPU_HALTED;
	logic SPM_ACTIVE, SPI_RAM_REQ, SPI_RAM_GRANT, BOOT_WINDOW, EMU_ENABLED, PROTECTED;
	logic [15:0] REG_ADDR, h_addr;
	logic [7:0] REG_WDATA, REG_RDATA;
	logic h_start, h_spm, h_ram;
	fcp_pkg::fcp_op_e h_op;
	fcp_pkg::fcp_req_s CPU_REQ, EMU_REQ, SPI_REQ;
	fcp_pkg::fcp_flash_cmd_s FLASH_CMD;
	fcp_pkg::fcp_resp_s CPU_RESP, EMU_RESP, SPI_RESP;
	int error_cnt = 0;
	int total_checks = 0;

	fcp_top uut (.CLK_SYS, .SYS_RST, .REG_WR, .REG_RD, .REG_IORAM, .REG_ADDR, .REG_WDATA,
		.REG_RDATA, .CPU_REQ, .EMU_REQ, .SPI_REQ, .EMU_PORT_EN, .SPM_ACTIVE, .CPU_HALTED,
		.SPI_RAM_REQ, .SPI_RAM_GRANT, .FLASH_CMD, .CPU_RESP, .EMU_RESP, .SPI_RESP,
		.BOOT_WINDOW, .EMU_ENABLED, .PROTECTED);
	fcp_spi_host host (.clk(CLK_SYS), .start(h_start), .op(h_op), .addr(h_addr),
		.spm_want(h_spm), .ram_want(h_ram), .req(SPI_REQ), .spm(SPM_ACTIVE),
		.ram_req(SPI_RAM_REQ));

	always #5 CLK_SYS = ~CLK_SYS;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task do_reset;
		@(posedge CLK_SYS);
		SYS_RST <= 1'b1;
		repeat (16) @(posedge CLK_SYS);
		SYS_RST <= 1'b0;
	endtask
	task wr(input logic io, input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_IORAM <= io;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
		#1;
	endtask
	task rd(input logic io, input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_IORAM <= io;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		chk("register", {8'h00, e}, {8'h00, REG_RDATA & m});
	endtask
	// Erase command stands in the second cycle after the write is taken
	task erase_cmd(input logic [7:0] pat, input logic ok);
		wr(0, 16'h0094, pat);
		@(posedge CLK_SYS);
		#1;
		chk("erase issued", {15'h0, ok}, {15'h0, FLASH_CMD.valid});
	endtask
	task freq(input logic emu, input fcp_pkg::fcp_op_e op, input logic [15:0] a,
		input logic ok);
		@(posedge CLK_SYS);
		if (emu)
			EMU_REQ <= '{1'b1, op, a, 8'h00};
		else
			CPU_REQ <= '{1'b1, op, a, 8'h00};
		@(posedge CLK_SYS);
		EMU_REQ.valid <= 1'b0;
		CPU_REQ.valid <= 1'b0;
		#1;
		chk("done", {15'h0, ok}, {15'h0, emu ? EMU_RESP.done : CPU_RESP.done});
		chk("denied", {15'h0, !ok}, {15'h0, emu ? EMU_RESP.denied : CPU_RESP.denied});
	endtask
	task spi(input fcp_pkg::fcp_op_e op, input logic [15:0] a, input logic ok);
		@(posedge CLK_SYS);
		h_start <= 1'b1;
		h_op <= op;
		h_addr <= a;
		@(posedge CLK_SYS);
		h_start <= 1'b0;
		@(posedge CLK_SYS);
		#1;
		chk("spi done", {15'h0, ok}, {15'h0, SPI_RESP.done});
		chk("spi denied", {15'h0, !ok}, {15'h0, SPI_RESP.denied});
	endtask
	task wait_emu;
		int i;
		for (i = 0; i < 200 && EMU_ENABLED !== 1'b1; i++) begin
			@(posedge CLK_SYS);
			#1;
		end
		if (i == 200) begin
			error_cnt++;
			give_verdict;
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{CLK_SYS, REG_WR, REG_RD, REG_IORAM, EMU_PORT_EN, CPU_HALTED} = '0;
		{h_start, h_spm, h_ram, REG_ADDR, REG_WDATA, h_addr} = '0;
		SYS_RST = 1'b1;
		h_op = fcp_pkg::FCP_OP_READ;
		CPU_REQ = '0;
		EMU_REQ = '0;
		do_reset;
		rd(0, 16'h00b2, 8'hc0, 8'h80);
		chk("boot window", 16'h1, {15'h0, BOOT_WINDOW});
		rd(1, 16'h2702, 8'hf0, 8'h00);
		// Arming write is taken on the 65th edge, just after the window
		repeat (59) @(posedge CLK_SYS);
		wr(0, 16'h00b2, 8'h40);
		rd(0, 16'h00b2, 8'hc0, 8'h00);
		chk("boot window", 16'h0, {15'h0, BOOT_WINDOW});
		freq(0, fcp_pkg::FCP_OP_WRITE, 16'h0200, 1'b0);
		wr(1, 16'h2702, 8'h20);
		freq(0, fcp_pkg::FCP_OP_WRITE, 16'h0000, 1'b1);
		spi(fcp_pkg::FCP_OP_WRITE, 16'h0400, 1'b0);
		@(posedge CLK_SYS);
		h_spm <= 1'b1;
		h_ram <= 1'b1;
		CPU_HALTED <= 1'b1;
		spi(fcp_pkg::FCP_OP_WRITE, 16'h0400, 1'b1);
		chk("cmd source", 16'(fcp_pkg::FCP_SRC_SPI), 16'(FLASH_CMD.src));
		chk("ram grant", 16'h0, {15'h0, SPI_RAM_GRANT});
		spi(fcp_pkg::FCP_OP_READ, 16'h0400, 1'b1);
		@(posedge CLK_SYS);
		CPU_HALTED <= 1'b0;
		spi(fcp_pkg::FCP_OP_PAGE_ERASE, 16'h0400, 1'b0);
		@(posedge CLK_SYS);
		h_spm <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		#1;
		chk("ram grant", 16'h1, {15'h0, SPI_RAM_GRANT});
		wr(0, 16'h00b7, 8'h06);
		erase_cmd(8'h55, 1'b1);
		chk("page addr", 16'h0600, FLASH_CMD.addr);
		wr(0, 16'h00b2, 8'h02);
		erase_cmd(8'haa, 1'b0);
		@(posedge CLK_SYS);
		EMU_PORT_EN <= 1'b1;
		wait_emu;
		wr(0, 16'h00b2, 8'h02);
		erase_cmd(8'haa, 1'b1);
		chk("cmd op", 16'(fcp_pkg::FCP_OP_MASS_ERASE), 16'(FLASH_CMD.op));
		rd(1, 16'h2702, 8'hf0, 8'h20);
		wr(1, 16'h2702, 8'h00);
		// Second life: armed inside the boot window
		do_reset;
		wr(0, 16'h00b2, 8'h40);
		wr(0, 16'h00b2, 8'h00);
		chk("protected", 16'h1, {15'h0, PROTECTED});
		chk("emulator enabled", 16'h0, {15'h0, EMU_ENABLED});
		wait_emu;
		wr(1, 16'h2702, 8'h20);
		freq(0, fcp_pkg::FCP_OP_WRITE, 16'h0010, 1'b0);
		freq(1, fcp_pkg::FCP_OP_WRITE, 16'h0010, 1'b0);
		wr(0, 16'h00b7, 8'h00);
		erase_cmd(8'h55, 1'b0);
		wr(1, 16'h2109, 8'h02);
		freq(0, fcp_pkg::FCP_OP_PAGE_ERASE, 16'h0800, 1'b0);
		freq(0, fcp_pkg::FCP_OP_PAGE_ERASE, 16'h0600, 1'b1);
		freq(1, fcp_pkg::FCP_OP_READ, 16'h0600, 1'b0);
		@(posedge CLK_SYS);
		h_spm <= 1'b1;
		CPU_HALTED <= 1'b1;
		spi(fcp_pkg::FCP_OP_READ, 16'h0600, 1'b0);
		freq(1, fcp_pkg::FCP_OP_MASS_ERASE, 16'h0000, 1'b1);
		chk("protected", 16'h1, {15'h0, PROTECTED});
		do_reset;
		#1;
		chk("protected", 16'h0, {15'h0, PROTECTED});
		give_verdict;
	end
endmodule
